// ### host_serial_model.sv
/*
  Host model driving the four-wire serial register port.
  Assumes callers run on the core clock; SCLK half period is 5 core cycles.
*/
`timescale 1ns/1ps

module host_serial_model
(
	// Pacing clock
	input  wire logic ref_clk_i,
	// Serial pins
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      sdi_o,
	input  wire logic sdo_i
);
	// ------------------------------------------------------------
	// Frame driver
	// ------------------------------------------------------------
	// Clock stands low and select high between frames
	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
	end

	task automatic pace(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask

	// Read flag, address LSB first, two zero pads, a don't-care, data LSB first
	task automatic xfer(input logic rd, input logic [3:0] a, input logic [7:0] d,
		output logic [4:0] q);
		logic [15:0] bits;
		bits = {d, 1'b1, 2'b00, a, rd};
		q = 5'h00;
		cs_n_o = 1'b0;
		pace(2);
		for (int i = 0; i < 16; i++)
		begin
			sclk_o = 1'b0;
			sdi_o = bits[i];
			pace(5);
			if (i >= 8 && i < 13)
				q[i-8] = sdo_i;
			sclk_o = 1'b1;
			pace(5);
		end
		sclk_o = 1'b0;
		// Released data line shows no stale value
		sdi_o = ~sdi_o;
		pace(6);
		cs_n_o = 1'b1;
		pace(6);
	endtask
endmodule // host_serial_model

// ### line_unit_config_assertions.sv
/*
  Port-level checker for the line unit configuration bank.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps

module line_unit_config_assertions
(
	// Clock and reset
	input wire logic                   ref_clk_i,
	input wire logic                   reset_i,
	// Watched inputs
	input wire logic                   register_clear_in_i,
	input wire logic                   chip_select_n_i,
	input wire logic                   transmit_negative_data_in_i,
	input wire logic                   analog_signal_lost_i,
	input wire logic                   digital_signal_lost_i,
	// Watched outputs
	input wire line_unit_pkg::tx_out_t tx_o,
	input wire line_unit_pkg::rx_out_t rx_o,
	input wire line_unit_pkg::cfg_t    cfg_o
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);

	tx_single_neg_a: assert property (cfg_o.tx_single_rail [*2] |-> !tx_o.neg)
		else $error("negative transmit output active in single-rail mode");
	tx_dual_neg_a: assert property (
		(transmit_negative_data_in_i && !cfg_o.tx_single_rail) [*5] |-> tx_o.neg)
		else $error("negative transmit input not passed in dual-rail mode");
	los_assert_a: assert property (
		(analog_signal_lost_i && cfg_o.analog_detector_en) [*4] |-> rx_o.signal_lost)
		else $error("enabled analog loss not reported");
	los_quiet_a: assert property (
		((!analog_signal_lost_i || !cfg_o.analog_detector_en)
		&& (!digital_signal_lost_i || !cfg_o.digital_detector_en)) [*4]
		|-> !rx_o.signal_lost)
		else $error("loss reported with no enabled detector active");
	codec_select_a: assert property (
		cfg_o.hdb3_sel == (cfg_o.rate == line_unit_pkg::RATE_E3))
		else $error("line code does not follow rate mode");
	rate_legal_a: assert property (cfg_o.rate != 2'b11)
		else $error("illegal rate mode");
	clear_pin_a: assert property (register_clear_in_i [*5] |=>
		cfg_o.rate == line_unit_pkg::RATE_DS3 && cfg_o.loop == line_unit_pkg::LOOP_NONE
		&& !cfg_o.codec_disable && cfg_o.equalizer_en && !cfg_o.tx_single_rail)
		else $error("clear pin did not restore defaults");
	reset_default_a: assert property ($fell(reset_i) |->
		cfg_o.loop == line_unit_pkg::LOOP_NONE && cfg_o.analog_detector_en
		&& cfg_o.digital_detector_en && tx_o == 2'b00)
		else $error("defaults wrong after reset");
	cfg_idle_a: assert property (
		(chip_select_n_i && !register_clear_in_i) [*6] |=> $stable(cfg_o))
		else $error("configuration changed with no frame");

	cover property (cfg_o.rate == line_unit_pkg::RATE_E3);
	cover property (rx_o.signal_lost);
	cover property (cfg_o.tx_single_rail && transmit_negative_data_in_i);
endmodule // line_unit_config_assertions

// ### line_unit_config_fields.sv
/*
  Configuration bank of the line unit: four-wire serial register
  port, the command fields and the datapath steering they drive.
  Assumes all pins are asynchronous to ref_clk_i and that the
  serial clock and recovered clocks run well below 125 MHz.
*/
`timescale 1ns/1ps

module line_unit_config_fields
(
	// Core clock and reset
	input  wire logic                   ref_clk_i,
	input  wire logic                   reset_i,
	// Serial register port
	input  wire logic                   serial_clock_i,
	input  wire logic                   chip_select_n_i,
	input  wire logic                   serial_data_in_i,
	output logic                        serial_data_out_o,
	input  wire logic                   register_clear_in_i,
	// Transmit data
	input  wire logic                   transmit_positive_data_in_i,
	input  wire logic                   transmit_negative_data_in_i,
	output line_unit_pkg::tx_out_t      tx_o,
	// Receive side
	input  wire logic                   first_receive_clock_i,
	input  wire logic                   second_receive_clock_i,
	input  wire logic                   recovered_pos_i,
	input  wire logic                   recovered_neg_i,
	input  wire logic                   analog_signal_lost_i,
	input  wire logic                   digital_signal_lost_i,
	input  wire logic                   code_violation_i,
	output line_unit_pkg::rx_out_t      rx_o,
	// Decoded configuration
	output line_unit_pkg::cfg_t         cfg_o
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [4:0] read_value
	(
		input logic [3:0] a,
		input logic [4:0] t,
		input logic [4:0] c,
		input logic [4:0] r,
		input logic [4:0] m,
		input logic [4:0] st
	);
		logic [4:0] v;
		v = 5'h00;
		case (a)
			line_unit_pkg::ADDR_STATUS:   v = st;
			line_unit_pkg::ADDR_TRANSMIT: v = t;
			line_unit_pkg::ADDR_CODEC:    v = c;
			line_unit_pkg::ADDR_RXOUT:    v = r;
			line_unit_pkg::ADDR_RATE:     v = m;
			default:                      v = 5'h00;
		endcase
		return v;
	endfunction

	function automatic logic pick_edge
	(
		input logic now,
		input logic prev,
		input logic inv
	);
		return inv ? (prev & ~now) : (now & ~prev);
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	line_unit_pkg::state_t r;
	line_unit_pkg::state_t next_r;

	logic [line_unit_pkg::NPIN-1:0] pins;
	logic                           sclk_rise;
	logic                           sclk_fall;
	logic                           cs_n;
	logic                           sdi;
	logic                           los;
	logic                           mute;
	logic                           launch;
	logic                           e3;
	logic [4:0]                     status;
	logic [7:0]                     sh_in;

	always_comb
	begin
		pins = '0;
		pins[line_unit_pkg::P_SCLK]  = serial_clock_i;
		pins[line_unit_pkg::P_CS_N]  = chip_select_n_i;
		pins[line_unit_pkg::P_SDI]   = serial_data_in_i;
		pins[line_unit_pkg::P_FIRST_CLK]  = first_receive_clock_i;
		pins[line_unit_pkg::P_SECOND_CLK] = second_receive_clock_i;
		pins[line_unit_pkg::P_RX_POS]     = recovered_pos_i;
		pins[line_unit_pkg::P_RX_NEG]     = recovered_neg_i;
		pins[line_unit_pkg::P_ANA_LOST]   = analog_signal_lost_i;
		pins[line_unit_pkg::P_DIG_LOST]   = digital_signal_lost_i;
		pins[line_unit_pkg::P_VIOL]       = code_violation_i;
		pins[line_unit_pkg::P_CLR]   = register_clear_in_i;
		pins[line_unit_pkg::P_TPOS]  = transmit_positive_data_in_i;
		pins[line_unit_pkg::P_TNEG]  = transmit_negative_data_in_i;
	end

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb
	begin
		next_r = r;

		// Pins are only read from the second stage onward
		next_r.s1 = pins;
		next_r.s2 = r.s1;
		next_r.s3 = {r.s2[line_unit_pkg::P_SECOND_CLK],
			r.s2[line_unit_pkg::P_FIRST_CLK],
			r.s2[line_unit_pkg::P_SCLK]};

		sclk_rise = r.s2[line_unit_pkg::P_SCLK] & ~r.s3[0];
		sclk_fall = ~r.s2[line_unit_pkg::P_SCLK] & r.s3[0];
		cs_n      = r.s2[line_unit_pkg::P_CS_N];
		sdi       = r.s2[line_unit_pkg::P_SDI];
		sh_in     = {sdi, r.shift[7:1]};

		// Combined loss: a disabled detector cannot assert it
		los = (r.s2[line_unit_pkg::P_ANA_LOST]
			& ~r.codec_reg[line_unit_pkg::ANA_DIS_BIT])
			| (r.s2[line_unit_pkg::P_DIG_LOST]
			& ~r.codec_reg[line_unit_pkg::DIG_DIS_BIT]);

		status = 5'h00;
		status[line_unit_pkg::ST_LOS_BIT]  = los;
		status[line_unit_pkg::ST_ANA_BIT] = r.s2[line_unit_pkg::P_ANA_LOST];
		status[line_unit_pkg::ST_DIG_BIT] = r.s2[line_unit_pkg::P_DIG_LOST];

		// --------------------------------------------------------
		// Serial port, LSB-first frame: rw, 4 address, 3 pad, 8 data
		// --------------------------------------------------------
		case (r.ser)
			line_unit_pkg::SER_IDLE:
			begin
				next_r.sdo = 1'b0;
				if (!cs_n)
				begin
					next_r.ser = line_unit_pkg::SER_HDR;
					next_r.cnt = 3'h0;
				end
			end
			line_unit_pkg::SER_HDR:
			begin
				if (sclk_rise)
				begin
					next_r.shift = sh_in;
					next_r.cnt   = r.cnt + 3'h1;
					if (r.cnt == line_unit_pkg::LAST_BIT)
					begin
						next_r.rd    = sh_in[0];
						next_r.addr  = sh_in[4:1];
						next_r.shift = {3'h0, read_value(sh_in[4:1],
							r.tx_reg, r.codec_reg, r.rx_reg,
							r.rate_reg, status)};
						next_r.ser   = line_unit_pkg::SER_DATA;
					end
				end
			end
			line_unit_pkg::SER_DATA:
			begin
				if (r.rd)
				begin
					// Read data leaves on falling edges, ahead of the
					// rising edge at which the host samples it
					if (sclk_fall)
					begin
						next_r.sdo   = r.shift[0];
						next_r.shift = {1'b0, r.shift[7:1]};
					end
					if (sclk_rise)
					begin
						next_r.cnt = r.cnt + 3'h1;
						if (r.cnt == line_unit_pkg::LAST_BIT)
							next_r.ser = line_unit_pkg::SER_DONE;
					end
				end
				else if (sclk_rise)
				begin
					next_r.shift = sh_in;
					next_r.cnt   = r.cnt + 3'h1;
					if (r.cnt == line_unit_pkg::LAST_BIT)
					begin
						next_r.ser = line_unit_pkg::SER_DONE;
						// Only defined bits are stored; the rest
						// stay zero and read back as zero
						case (r.addr)
							line_unit_pkg::ADDR_TRANSMIT:
								next_r.tx_reg =
									{4'h0, sh_in[0]};
							line_unit_pkg::ADDR_CODEC:
								next_r.codec_reg =
									{1'b0, sh_in[3:0]};
							line_unit_pkg::ADDR_RXOUT:
								next_r.rx_reg = sh_in[4:0];
							line_unit_pkg::ADDR_RATE:
								next_r.rate_reg =
									{1'b0, sh_in[3:0]};
							default:
								next_r.rx_reg = r.rx_reg;
						endcase
					end
				end
			end
			line_unit_pkg::SER_DONE:
			begin
				// Extra clocks past the frame are ignored
				next_r.ser = r.ser;
			end
			default:
			begin
				next_r.ser = line_unit_pkg::SER_IDLE;
			end
		endcase

		// Deselect aborts any frame; a partial write stores nothing
		if (cs_n && r.ser != line_unit_pkg::SER_IDLE)
		begin
			next_r.ser = line_unit_pkg::SER_IDLE;
			next_r.sdo = 1'b0;
		end

		// Register clear pin wins over a write in the same cycle
		if (r.s2[line_unit_pkg::P_CLR])
		begin
			next_r.tx_reg    = line_unit_pkg::REG_RESET;
			next_r.codec_reg = line_unit_pkg::REG_RESET;
			next_r.rx_reg    = line_unit_pkg::REG_RESET;
			next_r.rate_reg  = line_unit_pkg::REG_RESET;
		end

		// --------------------------------------------------------
		// Decoded configuration
		// --------------------------------------------------------
		e3 = r.rate_reg[line_unit_pkg::E3_BIT];
		next_r.cfg.tx_single_rail =
			r.tx_reg[line_unit_pkg::TX_SINGLE_BIT];
		next_r.cfg.codec_disable =
			r.codec_reg[line_unit_pkg::CODEC_DIS_BIT];
		next_r.cfg.hdb3_sel = e3;
		next_r.cfg.analog_detector_en =
			~r.codec_reg[line_unit_pkg::ANA_DIS_BIT];
		next_r.cfg.digital_detector_en =
			~r.codec_reg[line_unit_pkg::DIG_DIS_BIT];
		next_r.cfg.equalizer_en =
			~r.codec_reg[line_unit_pkg::EQ_DIS_BIT];
		if (e3)
			next_r.cfg.rate = line_unit_pkg::RATE_E3;
		else if (r.rate_reg[line_unit_pkg::RATE_BIT])
			next_r.cfg.rate = line_unit_pkg::RATE_STS1;
		else
			next_r.cfg.rate = line_unit_pkg::RATE_DS3;
		next_r.cfg.loop = line_unit_pkg::loop_mode_t'({
			r.rate_reg[line_unit_pkg::LOCAL_LOOP_BIT],
			r.rate_reg[line_unit_pkg::REMOTE_LOOP_BIT]});

		// --------------------------------------------------------
		// Transmit steering
		// --------------------------------------------------------
		next_r.tx.pos = r.s2[line_unit_pkg::P_TPOS];
		if (r.tx_reg[line_unit_pkg::TX_SINGLE_BIT])
			next_r.tx.neg = 1'b0;
		else
			next_r.tx.neg = r.s2[line_unit_pkg::P_TNEG];

		// --------------------------------------------------------
		// Receive steering
		// --------------------------------------------------------
		// Edges are found on synchronised copies, so data trails the pin
		// by three core cycles; the recovered clocks must stay slow
		launch = pick_edge(r.s2[line_unit_pkg::P_FIRST_CLK], r.s3[1],
			r.rx_reg[line_unit_pkg::CLK1_INV_BIT]);
		if (r.rx_reg[line_unit_pkg::SHARED_BIT])
			launch = launch | pick_edge(r.s2[line_unit_pkg::P_SECOND_CLK],
				r.s3[2], r.rx_reg[line_unit_pkg::CLK2_INV_BIT]);

		mute = r.rx_reg[line_unit_pkg::MUTE_BIT] & los;
		next_r.rx.signal_lost = los;
		next_r.rx.first_clock = r.s3[1];
		if (r.rx_reg[line_unit_pkg::SHARED_BIT])
			next_r.rx.shared = r.s3[2];
		else
			next_r.rx.shared = r.s2[line_unit_pkg::P_VIOL];

		if (mute)
		begin
			// Forced on the next core edge, not the receive clock
			next_r.rx.pos = 1'b0;
			next_r.rx.neg = 1'b0;
		end
		else if (launch)
		begin
			next_r.rx.pos = r.s2[line_unit_pkg::P_RX_POS];
			if (r.rx_reg[line_unit_pkg::RX_SINGLE_BIT])
				next_r.rx.neg = 1'b0;
			else
				next_r.rx.neg = r.s2[line_unit_pkg::P_RX_NEG];
		end

		// Single-rail holds the negative output low at once, even when
		// the field is set between two launch edges
		if (r.rx_reg[line_unit_pkg::RX_SINGLE_BIT])
			next_r.rx.neg = 1'b0;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			r      <= '0;
			r.s1   <= {line_unit_pkg::NPIN{1'b1}} & 13'h0002;
			r.s2   <= 13'h0002;
			r.ser  <= line_unit_pkg::SER_IDLE;
			r.cfg.analog_detector_en  <= 1'b1;
			r.cfg.digital_detector_en <= 1'b1;
			r.cfg.equalizer_en        <= 1'b1;
		end
		else
		begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign serial_data_out_o = r.sdo;
	assign tx_o              = r.tx;
	assign rx_o              = r.rx;
	assign cfg_o             = r.cfg;

endmodule // line_unit_config_fields

// ### line_unit_pkg.sv
/*
  Constants, field layouts and carrier types for the line unit
  configuration bank. Assumes a single 250 MHz core clock; every
  pin-side input is asynchronous to it.
*/
// Functional notes
// - Single-rail transmit: positive input only, encoded
// - Dual-rail transmit uses both data inputs
// - Codec disable bit turns encoder/decoder off
// - HDB3 in E3 mode, otherwise B3ZS
// - Analog detector off: only digital asserts loss
// - Digital detector off: only analog asserts loss
// - Equalizer disable bit turns equalizer off
// - Single-rail receive: negative output held low
// - Mute bit suppresses data during loss
// - Muting zeroes outputs without receive clock edge
// - Shared pin: violation flag or second clock
// - Second clock invert picks launch edge
// - First clock invert picks launch edge
// - Rate bit: 0 DS3, 1 STS-1
// - Rate bit ignored while E3 selected
// - E3 bit selects E3 mode
// - Local and remote loop bits decoded together
// - Loop pair: normal, remote, analog, digital
// - All fields reset and clear to zero
package line_unit_pkg;

	// ------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------
	localparam int          REG_W          = 5;
	localparam logic [4:0]  REG_RESET      = 5'h00;
	localparam logic [3:0]  ADDR_STATUS    = 4'h0;
	localparam logic [3:0]  ADDR_TRANSMIT  = 4'h1;
	localparam logic [3:0]  ADDR_CODEC     = 4'h2;
	localparam logic [3:0]  ADDR_RXOUT     = 4'h3;
	localparam logic [3:0]  ADDR_RATE      = 4'h4;
	localparam int          TX_SINGLE_BIT  = 0;
	localparam int          CODEC_DIS_BIT  = 3;
	localparam int          ANA_DIS_BIT    = 2;
	localparam int          DIG_DIS_BIT    = 1;
	localparam int          EQ_DIS_BIT     = 0;
	localparam int          RX_SINGLE_BIT  = 4;
	localparam int          MUTE_BIT       = 3;
	localparam int          SHARED_BIT     = 2;
	localparam int          CLK2_INV_BIT   = 1;
	localparam int          CLK1_INV_BIT   = 0;
	localparam int          RATE_BIT       = 3;
	localparam int          E3_BIT         = 2;
	localparam int          LOCAL_LOOP_BIT = 1;
	localparam int          REMOTE_LOOP_BIT = 0;
	localparam int          ST_LOS_BIT     = 3;
	localparam int          ST_ANA_BIT     = 2;
	localparam int          ST_DIG_BIT     = 1;

	// ------------------------------------------------------------
	// Serial frame and pin sampling
	// ------------------------------------------------------------
	localparam logic [2:0]  LAST_BIT       = 3'h7;
	localparam int          NPIN           = 13;
	localparam int          P_SCLK         = 0;
	localparam int          P_CS_N         = 1;
	localparam int          P_SDI          = 2;
	localparam int          P_FIRST_CLK    = 3;
	localparam int          P_SECOND_CLK   = 4;
	localparam int          P_RX_POS       = 5;
	localparam int          P_RX_NEG       = 6;
	localparam int          P_ANA_LOST     = 7;
	localparam int          P_DIG_LOST     = 8;
	localparam int          P_VIOL         = 9;
	localparam int          P_CLR          = 10;
	localparam int          P_TPOS         = 11;
	localparam int          P_TNEG         = 12;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		LOOP_NONE    = 2'b00,
		LOOP_REMOTE  = 2'b01,
		LOOP_ANALOG  = 2'b10,
		LOOP_DIGITAL = 2'b11
	} loop_mode_t;

	typedef enum logic [1:0] {
		RATE_DS3  = 2'b00,
		RATE_STS1 = 2'b01,
		RATE_E3   = 2'b10
	} rate_mode_t;

	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_HDR  = 2'b01,
		SER_DATA = 2'b10,
		SER_DONE = 2'b11
	} ser_state_t;

	typedef struct packed {
		logic       tx_single_rail;
		logic       codec_disable;
		logic       hdb3_sel;
		logic       analog_detector_en;
		logic       digital_detector_en;
		logic       equalizer_en;
		rate_mode_t rate;
		loop_mode_t loop;
	} cfg_t;

	typedef struct packed {
		logic pos;
		logic neg;
		logic signal_lost;
		logic first_clock;
		logic shared;
	} rx_out_t;

	typedef struct packed {
		logic pos;
		logic neg;
	} tx_out_t;

	typedef struct packed {
		logic [NPIN-1:0] s1;
		logic [NPIN-1:0] s2;
		logic [2:0]      s3;
		ser_state_t      ser;
		logic [2:0]      cnt;
		logic [7:0]      shift;
		logic            rd;
		logic [3:0]      addr;
		logic [4:0]      tx_reg;
		logic [4:0]      codec_reg;
		logic [4:0]      rx_reg;
		logic [4:0]      rate_reg;
		logic            sdo;
		cfg_t            cfg;
		rx_out_t         rx;
		tx_out_t         tx;
	} state_t;

endpackage

// ### testbench.sv
/*
  Self-checking bench for the line unit configuration bank.
  Assumes the host model paces frames on the core clock.
*/
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
	begin \
		compares++; \
		if ((got) !== (exp)) \
		begin \
			fail_count++; \
			$display("MISMATCH %s expected %h seen %h", nm, exp, got); \
		end \
	end

module testbench;
	logic                   clk, rst, sclk, cs_n, sdi, sdo, clr;
	logic                   tx_p, tx_n, rck1, rck2, rx_p, rx_n;
	logic                   ana_lost, dig_lost, viol;
	line_unit_pkg::tx_out_t tx;
	line_unit_pkg::rx_out_t rx;
	line_unit_pkg::cfg_t    cfg;
	int                     fail_count = 0;
	int                     compares = 0;

	line_unit_config_fields u_dut (.ref_clk_i(clk), .reset_i(rst),
		.serial_clock_i(sclk), .chip_select_n_i(cs_n), .serial_data_in_i(sdi),
		.serial_data_out_o(sdo), .register_clear_in_i(clr),
		.transmit_positive_data_in_i(tx_p), .transmit_negative_data_in_i(tx_n),
		.tx_o(tx), .first_receive_clock_i(rck1), .second_receive_clock_i(rck2),
		.recovered_pos_i(rx_p), .recovered_neg_i(rx_n),
		.analog_signal_lost_i(ana_lost), .digital_signal_lost_i(dig_lost),
		.code_violation_i(viol), .rx_o(rx), .cfg_o(cfg));
	host_serial_model u_host (.ref_clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n),
		.sdi_o(sdi), .sdo_i(sdo));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [4:0] q;
		u_host.xfer(1'b0, a, d, q);
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [4:0] exp);
		logic [4:0] q;
		u_host.xfer(1'b1, a, 8'h00, q);
		`CHK("read", exp, q)
	endtask

	// Present data, then move the first recovered clock
	task automatic rx_clk(input logic lvl, input logic dat);
		rx_p = dat;
		rx_n = dat;
		settle(4);
		rck1 = lvl;
		settle(5);
	endtask

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// A hang counts as a mismatch
	initial
	begin
		repeat (100000) @(posedge clk);
		fail_count++;
		close_out();
	end

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial
	begin
		{rst, clr, tx_p, tx_n, rck1, rck2, rx_p, rx_n, ana_lost, dig_lost, viol} = 11'h400;
		settle(20);
		rst = 1'b0;
		settle(4);
		rd_chk(4'h2, 5'h00);
		rd_chk(4'h3, 5'h00);
		rd_chk(4'h4, 5'h00);
		wr(4'h2, 8'hff);
		rd_chk(4'h2, 5'h0f);
		`CHK("codec_disable", 1'b1, cfg.codec_disable)
		`CHK("equalizer_en", 1'b0, cfg.equalizer_en)
		wr(4'h4, 8'hff);
		rd_chk(4'h4, 5'h0f);
		wr(4'h3, 8'hff);
		clr = 1'b1;
		settle(6);
		clr = 1'b0;
		settle(4);
		rd_chk(4'h3, 5'h00);
		`CHK("codec_enabled", 1'b0, cfg.codec_disable)
		`CHK("equalizer_on", 1'b1, cfg.equalizer_en)
		for (int i = 0; i < 16; i++)
		begin
			wr(4'h4, 8'(i));
			`CHK("loop", 2'(i), cfg.loop)
			`CHK("rate", i[2] ? 2'b10 : {1'b0, i[3]}, cfg.rate)
			`CHK("hdb3", i[2], cfg.hdb3_sel)
		end
		for (int d = 0; d < 4; d++)
		begin
			wr(4'h2, 8'(d << 1));
			for (int l = 0; l < 4; l++)
			begin
				ana_lost = l[1];
				dig_lost = l[0];
				settle(5);
				`CHK("signal_lost", (l[1] & ~d[1]) | (l[0] & ~d[0]), rx.signal_lost)
			end
		end
		{ana_lost, dig_lost} = 2'b00;
		wr(4'h2, 8'h00);
		for (int m = 0; m < 2; m++)
		begin
			wr(4'h1, 8'(m));
			{tx_p, tx_n} = 2'b11;
			settle(7);
			`CHK("tx_pos", 1'b1, tx.pos)
			`CHK("tx_neg", ~m[0], tx.neg)
			{tx_p, tx_n} = 2'b00;
			settle(5);
			`CHK("tx_pos_low", 1'b0, tx.pos)
		end
		for (int inv = 0; inv < 2; inv++)
		begin
			wr(4'h3, 8'(inv));
			rx_clk(1'b0, 1'b0);
			rx_clk(1'b1, 1'b0);
			rx_clk(1'b0, 1'b1);
			`CHK("rx_pos_fall", inv[0], rx.pos)
			`CHK("rx_neg_dual", inv[0], rx.neg)
			rx_clk(1'b1, 1'b1);
			rx_clk(1'b0, 1'b0);
			`CHK("rx_pos_hold", ~inv[0], rx.pos)
		end
		wr(4'h3, 8'h10);
		rx_clk(1'b1, 1'b1);
		rx_clk(1'b0, 1'b1);
		rx_clk(1'b1, 1'b1);
		`CHK("rx_pos_single", 1'b1, rx.pos)
		`CHK("rx_neg_single", 1'b0, rx.neg)
		wr(4'h3, 8'h08);
		rx_clk(1'b0, 1'b1);
		rx_clk(1'b1, 1'b1);
		ana_lost = 1'b1;
		settle(6);
		`CHK("muted_pos", 1'b0, rx.pos)
		`CHK("muted_neg", 1'b0, rx.neg)
		rd_chk(4'h0, 5'h0c);
		wr(4'h3, 8'h00);
		rx_clk(1'b0, 1'b1);
		rx_clk(1'b1, 1'b1);
		`CHK("unmuted_pos", 1'b1, rx.pos)
		ana_lost = 1'b0;
		viol = 1'b1;
		settle(5);
		`CHK("shared_viol", 1'b1, rx.shared)
		wr(4'h3, 8'h04);
		settle(6);
		`CHK("shared_clk_low", 1'b0, rx.shared)
		rck2 = 1'b1;
		settle(6);
		`CHK("shared_clk_high", 1'b1, rx.shared)
		wr(4'h3, 8'h06);
		{rx_p, rx_n} = 2'b00;
		settle(4);
		rck2 = 1'b0;
		settle(5);
		`CHK("clk2_fall_launch", 1'b0, rx.pos)
		{rx_p, rx_n} = 2'b11;
		settle(4);
		rck2 = 1'b1;
		settle(5);
		`CHK("clk2_rise_held", 1'b0, rx.pos)
		`CHK("first_clock", 1'b1, rx.first_clock)
		wr(4'h5, 8'hff);
		rd_chk(4'h3, 5'h06);
		close_out();
	end
endmodule // testbench

bind line_unit_config_fields line_unit_config_assertions u_chk (
	.ref_clk_i(ref_clk_i),
	.reset_i(reset_i),
	.register_clear_in_i(register_clear_in_i),
	.chip_select_n_i(chip_select_n_i),
	.transmit_negative_data_in_i(transmit_negative_data_in_i),
	.analog_signal_lost_i(analog_signal_lost_i),
	.digital_signal_lost_i(digital_signal_lost_i),
	.tx_o(tx_o),
	.rx_o(rx_o),
	.cfg_o(cfg_o)
);
